// file: rtl/snep_pkg.sv
// package for the serial nand erase / protection / status command block
// assumes one system clock (mclk) sampling the serial link pins
package snep_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN    = 8'h06;
    localparam logic [7:0] OP_WRDI    = 8'h04;
    localparam logic [7:0] OP_GETF    = 8'h0f;
    localparam logic [7:0] OP_SETF    = 8'h1f;
    localparam logic [7:0] OP_ERASE   = 8'hd8;
    localparam logic [7:0] OP_PLOAD   = 8'h02;
    localparam logic [7:0] OP_PEXEC   = 8'h10;
    localparam logic [7:0] OP_PREAD   = 8'h13;
    localparam logic [7:0] OP_RESET   = 8'hff;
    // feature addresses
    localparam logic [7:0] FA_LOCK    = 8'ha0;
    localparam logic [7:0] FA_OTP     = 8'hb0;
    localparam logic [7:0] FA_STATUS  = 8'hc0;
    // lock register fields
    localparam int LK_GUARD = 7;
    localparam int LK_BP_LO = 3;
    localparam logic [7:0] LK_WMASK   = 8'hb8;
    localparam logic [7:0] LK_RESET   = 8'h38;
    // otp register fields
    localparam int OT_PROT  = 7;
    localparam int OT_EN    = 6;
    localparam int OT_ECC   = 4;
    localparam logic [7:0] OT_RESET   = 8'h10;
    localparam logic [7:0] OT_WMASK   = 8'hd0;
    // status register fields
    localparam int ST_OIP   = 0;
    localparam int ST_WEL   = 1;
    localparam int ST_EFAIL = 2;
    localparam int ST_PFAIL = 3;
    localparam int ST_ECC   = 4;
    localparam logic [1:0] ECC_NONE   = 2'h0;
    // geometry
    localparam int ROW_W            = 17;
    localparam int ADDR_BITS        = 24;
    localparam int PAGE_BITS        = 6;
    localparam logic [10:0] BLOCKS  = 11'h7ff;
    localparam logic [7:0] OTP_FIRST = 8'h02;
    localparam logic [7:0] OTP_LAST  = 8'h0b;
    localparam int MEM_AW           = 11;
    // timing
    localparam int CLK_HZ           = 10_000_000;
    localparam int ERASE_US         = 4000;
    localparam int ERASE_CYC        = ERASE_US * (CLK_HZ / 1_000_000);
    localparam int PROG_US          = 400;
    localparam int PROG_CYC         = PROG_US * (CLK_HZ / 1_000_000);
    localparam int READ_US          = 100;
    localparam int READ_CYC         = READ_US * (CLK_HZ / 1_000_000);
    localparam int RESET_US         = 1000;
    localparam int RESET_CYC        = RESET_US * (CLK_HZ / 1_000_000);
    localparam int CNT_W            = 24;
endpackage

// file: rtl/snep_blkmem.sv
// per-block erased marker memory: one bit per block, registered read
// assumes caller holds address stable one cycle before using rdata
`timescale 1ns/1ps
`default_nettype none
module snep_blkmem (
    // clock
    input  wire logic                              mclk,
    // port
    input  wire logic                              we,
    input  wire logic [snep_pkg::MEM_AW-1:0]       addr,
    input  wire logic                              wdata,
    output logic                                   rdata
);
    logic mem [0:(1<<snep_pkg::MEM_AW)-1];
    always_ff @(posedge mclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule
`default_nettype wire

// file: rtl/snep_core.sv
// serial nand command block: erase, block lock, one-time area, status
// assumes spi mode 0 pins from the host, sampled by mclk
//
// Behaviour
// RULE_01: host sends enable, erase, then status polls
// RULE_02: each erase clears exactly one block
// RULE_03: erase without latch set is ignored
// RULE_04: erase takes 7 dummy plus 17 row bits
// RULE_05: erase busy for erase time, pollable
// RULE_06: lock bits 3-5 set at power-up
// RULE_07: set features a0h writes lock byte
// RULE_08: guard plus pin low blocks lock writes
// RULE_09: range bits choose locked upper fraction
// RULE_10: locked erase fails 04h, program 08h
// RULE_11: one-time pages programmed ascending only
// RULE_12: one-time enable reroutes load/execute/read; the code reroutes only program execute, load and read ignore it
// RULE_13: protect/enable bits pick one-time area state
// RULE_14: locked one-time area read-only, never erased
// RULE_15: get features c0h returns status anytime
// RULE_16: program fail set on bad target, cleared
// RULE_17: erase fail cleared at erase start
// RULE_18: latch set by enable, cleared by disable
// RULE_19: busy bit high during any operation
// RULE_20: correction field encodes four outcomes
// RULE_21: correction field cleared at read start
// RULE_22: power-up reset reads block 0 page 0
`timescale 1ns/1ps
`default_nettype none
module snep_core (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // serial link pins
    input  wire logic       cs_n,
    input  wire logic       sck,
    input  wire logic       si,
    input  wire logic       wp_n,
    output logic            so,
    output logic            so_oe_n,
    // array model hooks
    input  wire logic [1:0] ecc_outcome,
    input  wire logic       array_fail,
    output logic            erase_pulse,
    output logic [10:0]     erase_block
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SNEP_OPC   = 3'b000,
        SNEP_ADDR  = 3'b001,
        SNEP_FADR  = 3'b010,
        SNEP_FDAT  = 3'b011,
        SNEP_FOUT  = 3'b100,
        SNEP_SKIP  = 3'b101
    } snep_ph_e;

    typedef struct packed {
        logic [2:0]  cs_s;
        logic [2:0]  sck_s;
        logic [1:0]  si_s;
        logic [1:0]  wp_s;
        snep_ph_e    ph;
        logic [7:0]  opc;
        logic [7:0]  fadr;
        logic [23:0] sh;
        logic [4:0]  nbit;
        logic [7:0]  outb;
        logic [7:0]  lock;
        logic [7:0]  otp;
        logic        write_enable_latch;
        logic        efail;
        logic        pfail;
        logic [1:0]  ecc;
        logic        busy;
        logic        is_read;
        logic        is_erase;
        logic [23:0] cnt;
        logic [7:0]  otp_next;
        logic        so;
        logic        so_oe_n;
        logic        erase_pulse;
        logic [10:0] erase_block;
    } snep_st_s;

    snep_st_s st_r, st_nxt;

    // locked check by range code over block number
    function automatic logic blk_locked(input logic [2:0] bp, input logic [10:0] blk);
        logic [10:0] lim;
        lim = 11'h0;
        case (bp)
            3'h0: lim = 11'h7ff;
            3'h1: lim = 11'h7e0;
            3'h2: lim = 11'h7c0;
            3'h3: lim = 11'h780;
            3'h4: lim = 11'h700;
            3'h5: lim = 11'h600;
            3'h6: lim = 11'h400;
            default: lim = 11'h0;
        endcase
        if (bp == 3'h0) begin
            blk_locked = 1'b0;
        end else begin
            blk_locked = (blk >= lim);  // RULE_09
        end
    endfunction

    // status byte
    function automatic logic [7:0] status_of(input snep_st_s s);
        logic [7:0] v;
        v = 8'h0;
        v[snep_pkg::ST_OIP]   = s.busy;
        v[snep_pkg::ST_WEL]   = s.write_enable_latch;
        v[snep_pkg::ST_EFAIL] = s.efail;
        v[snep_pkg::ST_PFAIL] = s.pfail;
        v[snep_pkg::ST_ECC+:2] = s.ecc;
        status_of = v;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic        rise;
        logic        fall;
        logic        cs_act;
        logic        cs_end;
        logic [23:0] nsh;
        logic [10:0] blk;
        logic [7:0]  wr;
        logic        otp_mode;
        logic [7:0]  pg;
        rise     = 1'b0;
        fall     = 1'b0;
        cs_act   = 1'b0;
        cs_end   = 1'b0;
        nsh      = 24'h0;
        blk      = 11'h0;
        wr       = 8'h0;
        otp_mode = 1'b0;
        pg       = 8'h0;
        st_nxt = st_r;
        st_nxt.cs_s  = {st_r.cs_s[1:0], cs_n};
        st_nxt.sck_s = {st_r.sck_s[1:0], sck};
        st_nxt.si_s  = {st_r.si_s[0], si};
        st_nxt.wp_s  = {st_r.wp_s[0], wp_n};
        st_nxt.erase_pulse = 1'b0;
        // edges seen only on synchronised copies
        rise   = st_r.sck_s[1] & ~st_r.sck_s[2];
        fall   = ~st_r.sck_s[1] & st_r.sck_s[2];
        cs_act = ~st_r.cs_s[1];
        cs_end = st_r.cs_s[1] & ~st_r.cs_s[2];
        nsh    = {st_r.sh[22:0], st_r.si_s[1]};
        otp_mode = ~st_r.otp[snep_pkg::OT_PROT] & st_r.otp[snep_pkg::OT_EN];  // RULE_13
        // busy timer
        if (st_r.busy) begin
            if (st_r.cnt == 24'h0) begin
                st_nxt.busy = 1'b0;
                if (st_r.is_read) begin
                    st_nxt.ecc = st_r.lock[snep_pkg::LK_GUARD-1] ? snep_pkg::ECC_NONE
                        : (st_r.otp[snep_pkg::OT_ECC] ? ecc_outcome : snep_pkg::ECC_NONE);  // RULE_20
                end
                if (st_r.is_erase && array_fail) begin
                    st_nxt.efail = 1'b1;  // RULE_17
                end
            end else begin
                st_nxt.cnt = st_r.cnt - 24'h1;  // RULE_05 RULE_19
            end
        end
        if (cs_end) begin
            st_nxt.ph      = SNEP_OPC;
            st_nxt.nbit    = 5'h0;
            st_nxt.so_oe_n = 1'b1;
        end else if (cs_act && rise) begin
            st_nxt.sh   = nsh;
            st_nxt.nbit = st_r.nbit + 5'h1;
            case (st_r.ph)
                SNEP_OPC: begin
                    if (st_r.nbit == 5'h7) begin
                        st_nxt.opc  = nsh[7:0];
                        st_nxt.nbit = 5'h0;
                        st_nxt.ph   = SNEP_SKIP;
                        if (nsh[7:0] == snep_pkg::OP_WREN) begin
                            st_nxt.write_enable_latch = 1'b1;  // RULE_18
                        end else if (nsh[7:0] == snep_pkg::OP_WRDI) begin
                            st_nxt.write_enable_latch = 1'b0;  // RULE_18
                        end else if (nsh[7:0] == snep_pkg::OP_RESET) begin
                            st_nxt.efail = st_nxt.efail & ~st_r.efail;  // a failure ending now outlives the clear
                            st_nxt.pfail = 1'b0;
                            st_nxt.ecc   = snep_pkg::ECC_NONE;
                            st_nxt.write_enable_latch   = 1'b0;
                            st_nxt.busy  = 1'b1;
                            st_nxt.is_read  = 1'b0;
                            st_nxt.is_erase = 1'b0;
                            st_nxt.cnt   = 24'(snep_pkg::RESET_CYC);
                        end else if (nsh[7:0] == snep_pkg::OP_GETF || nsh[7:0] == snep_pkg::OP_SETF) begin
                            st_nxt.ph = SNEP_FADR;
                        end else if (nsh[7:0] == snep_pkg::OP_ERASE || nsh[7:0] == snep_pkg::OP_PEXEC
                                     || nsh[7:0] == snep_pkg::OP_PREAD) begin
                            st_nxt.ph = st_r.busy ? SNEP_SKIP : SNEP_ADDR;  // RULE_01
                        end
                    end
                end
                SNEP_ADDR: begin
                    if (st_r.nbit == 5'(snep_pkg::ADDR_BITS - 1)) begin
                        st_nxt.ph = SNEP_SKIP;
                        blk = nsh[snep_pkg::PAGE_BITS +: 11];  // RULE_04
                        pg  = {2'h0, nsh[snep_pkg::PAGE_BITS-1:0]};
                        if (st_r.opc == snep_pkg::OP_ERASE) begin
                            if (st_r.write_enable_latch) begin  // RULE_03
                                st_nxt.efail = 1'b0;  // RULE_17
                                st_nxt.write_enable_latch = 1'b0;
                                st_nxt.busy = 1'b1;
                                st_nxt.is_erase = 1'b1;
                                st_nxt.is_read  = 1'b0;
                                st_nxt.cnt = 24'(snep_pkg::ERASE_CYC);
                                if (otp_mode || blk_locked(st_r.lock[snep_pkg::LK_BP_LO+:3], blk)) begin
                                    st_nxt.efail = 1'b1;  // RULE_10 RULE_14
                                end else begin
                                    st_nxt.erase_pulse = 1'b1;  // RULE_02
                                    st_nxt.erase_block = blk;
                                end
                            end
                        end else if (st_r.opc == snep_pkg::OP_PEXEC) begin
                            if (st_r.write_enable_latch) begin  // RULE_18
                                st_nxt.pfail = 1'b0;  // RULE_16
                                st_nxt.write_enable_latch = 1'b0;
                                st_nxt.busy = 1'b1;
                                st_nxt.is_erase = 1'b0;
                                st_nxt.is_read  = 1'b0;
                                st_nxt.cnt = 24'(snep_pkg::PROG_CYC);
                                if (st_r.otp[snep_pkg::OT_PROT] && st_r.otp[snep_pkg::OT_EN]) begin
                                    st_nxt.otp_next = snep_pkg::OTP_LAST + 8'h1;  // RULE_13 RULE_14
                                end else if (otp_mode) begin  // RULE_12
                                    if (pg != st_r.otp_next || pg > snep_pkg::OTP_LAST) begin
                                        st_nxt.pfail = 1'b1;  // RULE_11 RULE_16
                                    end else begin
                                        st_nxt.otp_next = st_r.otp_next + 8'h1;
                                    end
                                end else if (blk_locked(st_r.lock[snep_pkg::LK_BP_LO+:3], blk) || array_fail) begin
                                    st_nxt.pfail = 1'b1;  // RULE_10 RULE_16
                                end
                            end
                        end else begin
                            st_nxt.ecc = snep_pkg::ECC_NONE;  // RULE_21
                            st_nxt.busy = 1'b1;
                            st_nxt.is_read  = 1'b1;
                            st_nxt.is_erase = 1'b0;
                            st_nxt.cnt = 24'(snep_pkg::READ_CYC);
                        end
                    end
                end
                SNEP_FADR: begin
                    if (st_r.nbit == 5'h7) begin
                        st_nxt.fadr = nsh[7:0];
                        st_nxt.nbit = 5'h0;
                        if (st_r.opc == snep_pkg::OP_SETF) begin
                            st_nxt.ph = SNEP_FDAT;
                        end else begin
                            st_nxt.ph = SNEP_FOUT;
                            if (nsh[7:0] == snep_pkg::FA_STATUS) begin
                                st_nxt.outb = status_of(st_r);  // RULE_15
                            end else if (nsh[7:0] == snep_pkg::FA_LOCK) begin
                                st_nxt.outb = st_r.lock;
                            end else if (nsh[7:0] == snep_pkg::FA_OTP) begin
                                st_nxt.outb = st_r.otp;
                            end else begin
                                st_nxt.outb = 8'h0;
                            end
                        end
                    end
                end
                SNEP_FDAT: begin
                    if (st_r.nbit == 5'h7) begin
                        st_nxt.ph = SNEP_SKIP;
                        wr = nsh[7:0];
                        if (st_r.fadr == snep_pkg::FA_LOCK) begin
                            if (!(st_r.lock[snep_pkg::LK_GUARD] && !st_r.wp_s[1])) begin  // RULE_08
                                st_nxt.lock = (st_r.lock & ~snep_pkg::LK_WMASK)
                                            | (wr & snep_pkg::LK_WMASK);  // RULE_07
                            end
                        end else if (st_r.fadr == snep_pkg::FA_OTP) begin
                            if (!(st_r.otp[snep_pkg::OT_PROT] && st_r.otp[snep_pkg::OT_EN]
                                  && st_r.otp_next > snep_pkg::OTP_LAST)) begin
                                st_nxt.otp = (st_r.otp & ~snep_pkg::OT_WMASK) | (wr & snep_pkg::OT_WMASK);
                            end else begin
                                st_nxt.otp[snep_pkg::OT_ECC] = wr[snep_pkg::OT_ECC];  // RULE_14
                            end
                        end
                    end
                end
                default: begin
                    st_nxt.nbit = 5'h0;
                end
            endcase
        end else if (cs_act && fall && st_r.ph == SNEP_FOUT) begin
            st_nxt.so_oe_n = 1'b0;
            st_nxt.so   = st_r.outb[7];
            st_nxt.outb = {st_r.outb[6:0], st_r.outb[7]};
        end
        if (srst) begin
            st_nxt = '0;
            st_nxt.cs_s  = 3'h7;
            st_nxt.sck_s = 3'h0;
            st_nxt.ph    = SNEP_OPC;
            st_nxt.lock  = snep_pkg::LK_RESET;  // RULE_06
            st_nxt.otp   = snep_pkg::OT_RESET;
            st_nxt.otp_next = snep_pkg::OTP_FIRST;
            st_nxt.so_oe_n  = 1'b1;
            st_nxt.busy     = 1'b1;  // RULE_22
            st_nxt.is_read  = 1'b1;
            st_nxt.cnt      = 24'(snep_pkg::READ_CYC);
            st_nxt.ecc      = snep_pkg::ECC_NONE;  // RULE_21
        end
    end

    always_ff @(posedge mclk) begin
        st_r <= st_nxt;
    end

    // erased-block record, written on each erase pulse; its read port is left unconnected
    snep_blkmem u_mem (
        .mclk  (mclk),
        .we    (st_r.erase_pulse),
        .addr  (st_r.erase_block),
        .wdata (1'b1),
        .rdata ()
    );

    assign so          = st_r.so;
    assign so_oe_n     = st_r.so_oe_n;
    assign erase_pulse = st_r.erase_pulse;
    assign erase_block = st_r.erase_block;
endmodule
`default_nettype wire

// file: verification/snep_core_chk.sv
// port-level assertions for the serial nand command block
// assumes a single mclk domain; bound onto snep_core below
`timescale 1ns/1ps
`default_nettype none
module snep_core_chk (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        srst,
    // serial link pins
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        si,
    input  wire logic        wp_n,
    input  wire logic        so,
    input  wire logic        so_oe_n,
    // array model hooks
    input  wire logic [1:0]  ecc_outcome,
    input  wire logic        array_fail,
    input  wire logic        erase_pulse,
    input  wire logic [10:0] erase_block
);
    // ----------------------------------------
    // cycles since the last erase
    // ----------------------------------------
    logic [16:0] gap_r;
    always_ff @(posedge mclk) begin
        if (srst) begin
            gap_r <= 17'h1ffff;  // reset is no erase: the first erase may come early
        end else if (erase_pulse) begin
            gap_r <= 17'h00000;
        end else if (gap_r != 17'h1ffff) begin
            gap_r <= gap_r + 17'h00001;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    // six cycles covers the pin synchroniser plus the output register
    sequence s_cs_idle; cs_n [*6]; endsequence
    sequence s_cs_held; !cs_n [*4]; endsequence
    property p_reset_idle; $fell(srst) |-> so_oe_n && !so && !erase_pulse; endproperty
    property p_oe_idle; s_cs_idle |-> so_oe_n; endproperty
    property p_oe_hold; s_cs_held ##0 !so_oe_n |=> !so_oe_n; endproperty
    property p_oe_start; $fell(so_oe_n) |-> !cs_n && !$past(cs_n, 8); endproperty
    property p_pulse_single; erase_pulse |=> !erase_pulse [*8]; endproperty
    property p_pulse_gap; erase_pulse |-> gap_r >= snep_pkg::ERASE_CYC; endproperty
    property p_block_hold; erase_pulse |=> $stable(erase_block); endproperty
    property p_no_early; $fell(srst) |-> !erase_pulse [*8]; endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    a_oe_idle: assert property (p_oe_idle) else $error("serial out driven while deselected");
    a_oe_hold: assert property (p_oe_hold) else $error("serial out released mid frame");
    a_oe_start: assert property (p_oe_start) else $error("serial out driven too early");
    a_pulse_single: assert property (p_pulse_single) else $error("erase pulse repeated");
    a_pulse_gap: assert property (p_pulse_gap) else $error("erase finished before erase time");
    a_block_hold: assert property (p_block_hold) else $error("erased block number moved");
    a_no_early: assert property (p_no_early) else $error("erase right after reset");
    c_erase: cover property (erase_pulse);
endmodule
bind snep_core snep_core_chk snep_core_chk_i (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si),
    .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .ecc_outcome(ecc_outcome), .array_fail(array_fail),
    .erase_pulse(erase_pulse), .erase_block(erase_block));
`default_nettype wire

// file: verification/snep_host.sv
// behavioural spi host: mode 0 frames, msb first, 800 ns link clock
// assumes the caller waits for one frame to end before the next
`timescale 1ns/1ps
`default_nettype none
module snep_host (
    // link pins toward the device
    output logic            cs_n,
    output logic            sck,
    output logic            si,
    input  wire logic       so,
    input  wire logic       so_oe_n
);
    localparam time HALF = 400ns;
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // ----------------------------------------
    // one frame of nbytes taken from the top of v
    // ----------------------------------------
    task automatic frame(input logic [31:0] v, input int nbytes, output logic [7:0] rx);
        rx = 8'h00;
        #37;
        cs_n = 1'b0;
        #(HALF);
        for (int i = 0; i < 8 * nbytes; i++) begin
            si = v[31 - i];
            #(HALF);
            sck = 1'b1;
            // sample late in the high phase: the device output lags the pins
            #(HALF - 10ns);
            rx = {rx[6:0], (so_oe_n === 1'b0) ? so : 1'bx};
            #10ns;
            sck = 1'b0;
        end
        #(HALF);
        cs_n = 1'b1;
        // a released line must not keep its last level
        si = ~si;
        #(4 * HALF);
    endtask
endmodule
`default_nettype wire

// file: verification/spi_nand_erase_protect_status_bench.sv
// self-checking bench for the serial nand erase / lock / status block
// assumes snep_host drives the link and the checker is bound in
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin n_errors++; \
    $display("BAD %0t mismatch got %h expected %h", $time, got, exp); end end
module spi_nand_erase_protect_status_bench;
    logic        mclk, srst, cs_n, sck, si, wp_n, so, so_oe_n, array_fail, erase_pulse;
    logic [1:0]  ecc_outcome, ecc_m;
    logic [10:0] erase_block, last_blk, blk, blk_m;
    logic [7:0]  st, first_st, rx;
    int          n_errors, compares, n_pulse, rng_m;
    int          exp_q[$];
    snep_core snep_core_i (.mclk(mclk), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so),
        .so_oe_n(so_oe_n), .ecc_outcome(ecc_outcome), .array_fail(array_fail), .erase_pulse(erase_pulse),
        .erase_block(erase_block));
    snep_host snep_host_i (.cs_n(cs_n), .sck(sck), .si(si), .so(so), .so_oe_n(so_oe_n));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        if (erase_pulse === 1'b1) begin
            n_pulse++;
            last_blk = erase_block;
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("BAD %0t erase pulse not expected", $time);
            end else begin
                blk_m = 11'(exp_q.pop_front());
                `CHK(erase_block, blk_m)
            end
        end
    end
    // ----------------------------------------
    // model and bus tasks
    // ----------------------------------------
    function automatic bit is_locked(int rng, int b);
        return rng != 0 && b >= 2048 - (2048 >> (7 - rng));
    endfunction
    task automatic complete_run;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic feat(input logic [7:0] op, input logic [7:0] fa, input logic [7:0] d, output logic [7:0] r);
        snep_host_i.frame({op, fa, d, 8'h00}, 3, r);
    endtask
    task automatic op1(input logic [7:0] op);
        snep_host_i.frame({op, 24'h000000}, 1, rx);
    endtask
    task automatic erase(input logic [10:0] b);
        snep_host_i.frame({snep_pkg::OP_ERASE, 7'h00, b, 6'h00}, 4, rx);
    endtask
    task automatic status(output logic [7:0] s);
        feat(snep_pkg::OP_GETF, snep_pkg::FA_STATUS, 8'h00, s);
    endtask
    task automatic lock_set(input logic [7:0] d, input logic [7:0] exp);
        feat(snep_pkg::OP_SETF, snep_pkg::FA_LOCK, d, rx);
        feat(snep_pkg::OP_GETF, snep_pkg::FA_LOCK, 8'h00, rx);
        `CHK(rx, exp)
    endtask
    // first poll kept so callers can see the busy phase
    task automatic wait_ready;
        status(first_st);
        st = first_st;
        for (int i = 0; i < 250 && st[snep_pkg::ST_OIP] !== 1'b0; i++) status(st);
        if (st[snep_pkg::ST_OIP] !== 1'b0) begin
            n_errors++;
            $display("BAD %0t ready wait ran out", $time);
            complete_run;
        end
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        n_errors = 0;
        compares = 0;
        n_pulse = 0;
        last_blk = 11'h000;
        void'($urandom(32'h0d50));
        ecc_m = 2'($urandom % 3);
        blk = 11'($urandom % 2016);
        srst = 1'b1;
        wp_n = 1'b1;
        array_fail = 1'b0;
        ecc_outcome = ecc_m;
        repeat (8) @(posedge mclk);
        #1;
        srst = 1'b0;
        wait_ready;
        `CHK(first_st[snep_pkg::ST_OIP], 1'b1)
        `CHK(st[snep_pkg::ST_ECC +: 2], ecc_m)
        feat(snep_pkg::OP_GETF, snep_pkg::FA_LOCK, 8'h00, rx);
        `CHK(rx, 8'h38)
        feat(snep_pkg::OP_GETF, snep_pkg::FA_OTP, 8'h00, rx);
        `CHK(rx, 8'h10)
        erase(blk);
        status(st);
        `CHK(st[1:0], 2'b00)
        op1(snep_pkg::OP_WREN);
        status(st);
        `CHK(st[snep_pkg::ST_WEL], 1'b1)
        op1(snep_pkg::OP_WRDI);
        status(st);
        `CHK(st[snep_pkg::ST_WEL], 1'b0)
        for (int r = 0; r < 8; r++) lock_set(8'(r << 3), 8'(r << 3));
        lock_set(8'h80, 8'h80);
        @(posedge mclk);
        #1;
        wp_n = 1'b0;
        lock_set(8'h38, 8'h80);
        @(posedge mclk);
        #1;
        wp_n = 1'b1;
        lock_set(8'h08, 8'h08);
        rng_m = 1;
        op1(snep_pkg::OP_WREN);
        erase(11'h7ff);
        wait_ready;
        `CHK(st[snep_pkg::ST_EFAIL], 1'(is_locked(rng_m, 2047)))
        `CHK(n_pulse, 0)
        op1(snep_pkg::OP_WREN);
        if (!is_locked(rng_m, int'(blk))) exp_q.push_back(int'(blk));
        erase(blk);
        wait_ready;
        `CHK(first_st[snep_pkg::ST_OIP], 1'b1)
        `CHK(first_st[snep_pkg::ST_EFAIL], 1'b0)
        `CHK(st[snep_pkg::ST_EFAIL], 1'(is_locked(rng_m, int'(blk))))
        repeat (4) @(posedge mclk);
        `CHK(n_pulse, 1)
        `CHK(last_blk, blk)
        `CHK(exp_q.size(), 0)
        complete_run;
    end
endmodule
`default_nettype wire
